/* lvd_defines.svh */
// Register map, field positions, reset values and timing counts of the low-voltage detector
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH
`define LVD_ADDR_DIR   16'hFF2C
`define LVD_ADDR_CTL   16'hFFBE
`define LVD_ADDR_LVL   16'hFFBF
`define LVD_CTL_EN     7
`define LVD_CTL_SRC    2
`define LVD_CTL_MODE   1
`define LVD_CTL_FLAG   0
`define LVD_CTL_RST    8'h00
`define LVD_LVL_RST    8'h00
`define LVD_DIR_RST    8'hFF
`define LVD_DIR_PIN    0
`define LVD_CLK_MHZ    100
`define LVD_STAB_US    10
`define LVD_FILTER_US  200
`define LVD_FILTER_CYC (`LVD_FILTER_US * `LVD_CLK_MHZ)
`endif

/* lvd_pkg.sv */
// Types shared by the low-voltage detector modules
package lvd_pkg;
  typedef enum logic {
    LVD_SRC_SUPPLY = 1'b0,
    LVD_SRC_EXT    = 1'b1
  } lvd_src_type;
  typedef enum logic {
    LVD_MODE_IRQ   = 1'b0,
    LVD_MODE_RESET = 1'b1
  } lvd_mode_type;
endpackage

/* lvd_cmp_if.sv */
// Comparator results before and after synchronisation
`timescale 1ns/1ps
`default_nettype none
interface lvd_cmp_if;
  logic [1:0] raw;   // Bit 0 supply below, bit 1 external below
  logic [1:0] sync;
  modport user     (output raw, input sync);
  modport sync_side(input raw, output sync);
endinterface // lvd_cmp_if
`default_nettype wire

/* lvd_sync.sv */
// Two-flop synchroniser for the comparator outputs
`timescale 1ns/1ps
`default_nettype none
module lvd_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic         clk_i,    // System clock
  input  wire logic         resetn_i, // Synchronous reset, active low
  lvd_cmp_if.sync_side      cmp       // Raw in, synchronised out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= cmp.raw[g];
          sync_q <= meta_q;
        end
      end
      assign cmp.sync[g] = sync_q;
    end
  endgenerate
endmodule // lvd_sync
`default_nettype wire

/* lvd_top.sv */
// Low-voltage detector control registers, level filter, reset and interrupt generation
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
module lvd_top
  import lvd_pkg::*;
#(
  parameter int FILTER_CYCLES = `LVD_FILTER_CYC,
  parameter int CNT_W         = 15
) (
  input  wire logic        CLK_I,          // System clock, 100 MHz
  input  wire logic        RESETN_I,       // Non-detector reset, active low
  input  wire logic [15:0] ADDR_I,         // CPU address
  input  wire logic        BYTE_WR_I,      // Byte write strobe
  input  wire logic [7:0]  WDATA_I,        // Byte write data
  input  wire logic        BIT_WR_I,       // Single-bit write strobe
  input  wire logic [2:0]  BIT_SEL_I,      // Bit number for bit write
  input  wire logic        BIT_VAL_I,      // Bit value for bit write
  input  wire logic        RD_I,           // Read strobe
  output logic      [7:0]  RDATA_O,        // Read data, one cycle after RD_I
  input  wire logic        SUPPLY_BELOW_I, // Supply comparator, 1 when below
  input  wire logic        EXT_BELOW_I,    // External pin comparator, 1 when below
  output logic             COMP_EN_O,      // Comparator enable
  output logic      [3:0]  LEVEL_CODE_O,   // Supply threshold code
  output logic      [7:0]  PORT12_DIR_O,   // Port 12 direction
  output logic             INT_RESET_O,    // Detector internal reset request
  output logic             DET_IRQ_O,      // Detector interrupt pulse
  output logic             IRQ_REQ_FLAG_O, // Sticky interrupt request flag
  input  wire logic        IRQ_REQ_CLR_I,  // Clear request flag
  output logic             IRQ_MASK_O,     // Interrupt mask flag
  input  wire logic        MASK_WR_I,      // Write mask flag
  input  wire logic        MASK_VAL_I,     // Mask value
  output logic             RST_SRC_FLAG_O, // Detector reset-source flag
  input  wire logic        RST_SRC_CLR_I   // Clear reset-source flag
);
  localparam logic [CNT_W-1:0] FILT_LIM = CNT_W'(FILTER_CYCLES - 1);

  logic              en_q;
  lvd_src_type       src_q;
  lvd_mode_type      mode_q;
  logic              flag_q;
  logic              flag_d;
  logic [3:0]        lvl_q;
  logic              dir0_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              irq_q;
  logic              req_q;
  logic              mask_q;
  logic              rsf_q;
  logic              int_rst_q;
  logic [7:0]        rdata_q;
  logic              wr_any;
  logic              sel_below;
  logic              below_act;
  logic [7:0]        ctl_rd;
  logic [7:0]        lvl_rd;
  logic [7:0]        dir_rd;
  logic [7:0]        cur_rd;
  logic [7:0]        wval;

  lvd_cmp_if cmp ();
  assign cmp.raw = {EXT_BELOW_I, SUPPLY_BELOW_I};

  ////////////////////////////////////////////////////////////////////////
  // sync comparators
  lvd_sync #(.WIDTH(2)) u_sync (
    .clk_i    (CLK_I),
    .resetn_i (RESETN_I),
    .cmp      (cmp)
  );

  ////////////////////////////////////////////////////////////////////////
  assign ctl_rd = {en_q, 4'h0, src_q, mode_q, flag_q};
  assign lvl_rd = {4'h0, lvl_q};
  assign dir_rd = {7'h7F, dir0_q};

  always_comb begin
    case (ADDR_I)
      `LVD_ADDR_CTL: cur_rd = ctl_rd;
      `LVD_ADDR_LVL: cur_rd = lvl_rd;
      `LVD_ADDR_DIR: cur_rd = dir_rd;
      default:       cur_rd = 8'h00;
    endcase
  end

  always_comb begin
    wval = cur_rd;
    if (BYTE_WR_I) begin
      wval = WDATA_I;
    end else begin
      wval[BIT_SEL_I] = BIT_VAL_I;
    end
  end
  // CPU is held in reset while the detector resets it, so writes are dropped then
  assign wr_any = (BYTE_WR_I | BIT_WR_I) & ~int_rst_q;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rdata_q <= 8'h00;
    end else if (RD_I) begin
      rdata_q <= cur_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control reset and write
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      en_q   <= 1'(`LVD_CTL_RST >> `LVD_CTL_EN);
      src_q  <= LVD_SRC_SUPPLY;
      mode_q <= LVD_MODE_IRQ;
    end else if (wr_any && ADDR_I == `LVD_ADDR_CTL) begin
      en_q   <= wval[`LVD_CTL_EN];
      src_q  <= lvd_src_type'(wval[`LVD_CTL_SRC]);
      mode_q <= lvd_mode_type'(wval[`LVD_CTL_MODE]);
    end
  end

  // level select kept over own reset
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      lvl_q <= 4'(`LVD_LVL_RST);
    end else if (wr_any && ADDR_I == `LVD_ADDR_LVL) begin
      lvl_q <= wval[3:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || int_rst_q) begin
      dir0_q <= 1'b1;
    end else if (wr_any && ADDR_I == `LVD_ADDR_DIR) begin
      dir0_q <= wval[`LVD_DIR_PIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external ignores level code
  assign sel_below = (src_q == LVD_SRC_EXT) ? cmp.sync[1] : cmp.sync[0];
  assign below_act = en_q & sel_below;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || !below_act) begin
      cnt_q <= '0;
    end else if (cnt_q != FILT_LIM) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign flag_d = below_act & (cnt_q == FILT_LIM);

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      int_rst_q <= 1'b0;
    end else begin
      int_rst_q <= en_q & (mode_q == LVD_MODE_RESET) & flag_d;
    end
  end

  // pulse on both crossings; falls out since disabling drops the flag
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (mode_q == LVD_MODE_IRQ) & (flag_q ^ flag_d);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      req_q <= 1'b0;
    end else if (irq_q) begin
      req_q <= 1'b1;
    end else if (IRQ_REQ_CLR_I) begin
      req_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || int_rst_q) begin
      mask_q <= 1'b1;
    end else if (MASK_WR_I) begin
      mask_q <= MASK_VAL_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rsf_q <= 1'b0;
    end else if (int_rst_q) begin
      rsf_q <= 1'b1;
    end else if (RST_SRC_CLR_I) begin
      rsf_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign RDATA_O        = rdata_q;
  assign COMP_EN_O      = en_q;
  assign LEVEL_CODE_O   = lvl_q;
  assign PORT12_DIR_O   = dir_rd;
  assign INT_RESET_O    = int_rst_q;
  assign DET_IRQ_O      = irq_q;
  assign IRQ_REQ_FLAG_O = req_q;
  assign IRQ_MASK_O     = mask_q;
  assign RST_SRC_FLAG_O = rsf_q;

  ////////////////////////////////////////////////////////////////////////
  // Helper: consecutive cycles below while enabled
  logic [CNT_W:0] run_q;
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I || !below_act) begin
      run_q <= '0;
    end else if (run_q != {1'b1, {CNT_W{1'b0}}}) begin
      run_q <= run_q + 1'b1;
    end
  end

  a_ctl_reset: assert property (@(posedge CLK_I) !RESETN_I |=> ctl_rd == 8'h00)
    else $error("control not cleared by reset");
  a_own_keep: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    int_rst_q |=> ($stable(en_q) && $stable(src_q) && $stable(mode_q) && $stable(lvl_q)))
    else $error("detector reset changed settings");
  a_lvl_reset: assert property (@(posedge CLK_I) !RESETN_I |=> LEVEL_CODE_O == 4'h0)
    else $error("level select not cleared");
  a_dir_reset: assert property (@(posedge CLK_I) (!RESETN_I || int_rst_q) |=> PORT12_DIR_O == 8'hFF)
    else $error("direction not set by reset");
  a_mask_reset: assert property (@(posedge CLK_I) (!RESETN_I || int_rst_q) |=> IRQ_MASK_O)
    else $error("mask not set by reset");
  a_src_flag: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    INT_RESET_O |=> RST_SRC_FLAG_O)
    else $error("reset-source flag not set");
  a_flag_delay: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    $rose(flag_q) |-> $past(run_q) >= (CNT_W+1)'(FILTER_CYCLES - 1))
    else $error("level flag set too early");
  a_flag_off: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!en_q || !sel_below) |=> !flag_q)
    else $error("flag set while disabled or above");
  a_irq_edge: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (mode_q == LVD_MODE_IRQ && flag_q != flag_d) |=> DET_IRQ_O ##1 IRQ_REQ_FLAG_O)
    else $error("crossing gave no interrupt");
  a_rst_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (flag_q && $past(mode_q) == LVD_MODE_RESET) |-> INT_RESET_O)
    else $error("reset not held while below");
  a_rst_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !flag_q |-> !INT_RESET_O)
    else $error("reset held while above");
endmodule // lvd_top
`default_nettype wire

/* lvd_cmp_model.sv */
// Comparator model: supply and external-pin voltages against their thresholds
`timescale 1ns/1ps
`default_nettype none
module lvd_cmp_model (
  input  wire logic       en_i,           // Comparator enable
  input  wire logic [3:0] code_i,         // Supply threshold code
  input  var  int         supply_mv_i,    // Supply in mV
  input  var  int         ext_mv_i,       // Pin voltage in mV
  output logic            supply_below_o, // 1 when supply below
  output logic            ext_below_o     // 1 when pin below
);
  localparam int LVL_MV [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                                 3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
  localparam int EXT_MV = 1210;
  // Switched-off comparator never reports below
  assign supply_below_o = en_i && (supply_mv_i < LVL_MV[code_i]);
  assign ext_below_o    = en_i && (ext_mv_i < EXT_MV);
endmodule // lvd_cmp_model
`default_nettype wire

/* low_voltage_detect_control_tb.sv */
// Self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module low_voltage_detect_control_tb;
  localparam int FLT = 8;
  logic CLK_I = 0, RESETN_I = 0, BYTE_WR_I = 0, BIT_WR_I = 0, BIT_VAL_I = 0, RD_I = 0;
  logic IRQ_REQ_CLR_I = 0, MASK_WR_I = 0, MASK_VAL_I = 0, RST_SRC_CLR_I = 0;
  logic [15:0] ADDR_I = 0;
  logic [7:0]  WDATA_I = 0, RDATA_O, PORT12_DIR_O, d;
  logic [2:0]  BIT_SEL_I = 0;
  logic [3:0]  LEVEL_CODE_O, code;
  logic SUPPLY_BELOW_I, EXT_BELOW_I, COMP_EN_O, INT_RESET_O, DET_IRQ_O, IRQ_REQ_FLAG_O, IRQ_MASK_O, RST_SRC_FLAG_O;
  int err_count = 0, checked = 0, seed = 49, cyc = 0, n, sup_mv = 5000, ext_mv = 3000, thr;

  lvd_top #(.FILTER_CYCLES(FLT), .CNT_W(15)) u_dut (.CLK_I, .RESETN_I, .ADDR_I, .BYTE_WR_I, .WDATA_I, .BIT_WR_I,
    .BIT_SEL_I, .BIT_VAL_I, .RD_I, .RDATA_O, .SUPPLY_BELOW_I, .EXT_BELOW_I, .COMP_EN_O, .LEVEL_CODE_O,
    .PORT12_DIR_O, .INT_RESET_O, .DET_IRQ_O, .IRQ_REQ_FLAG_O, .IRQ_REQ_CLR_I, .IRQ_MASK_O, .MASK_WR_I,
    .MASK_VAL_I, .RST_SRC_FLAG_O, .RST_SRC_CLR_I);
  lvd_cmp_model u_cmp (.en_i(COMP_EN_O), .code_i(LEVEL_CODE_O), .supply_mv_i(sup_mv), .ext_mv_i(ext_mv),
    .supply_below_o(SUPPLY_BELOW_I), .ext_below_o(EXT_BELOW_I));

  initial begin
    forever #5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= v;
    BYTE_WR_I <= 1'b1;
    @(posedge CLK_I);
    BYTE_WR_I <= 1'b0;
  endtask
  task automatic bw(input logic [15:0] a, input logic [2:0] b, input logic v);
    @(posedge CLK_I);
    ADDR_I <= a;
    BIT_SEL_I <= b;
    BIT_VAL_I <= v;
    BIT_WR_I <= 1'b1;
    @(posedge CLK_I);
    BIT_WR_I <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1;
    `CHK(RDATA_O, e)
  endtask
  task automatic setv(input int s, input int e);
    @(posedge CLK_I);
    sup_mv <= s;
    ext_mv <= e;
  endtask
  // Bounded wait: 0 irq pulse, 1 reset high, 2 reset low
  task automatic wait_ev(input int s, output int k);
    #1;
    k = 0;
    while (k < 40 && !(s == 0 ? DET_IRQ_O === 1'b1 : s == 1 ? INT_RESET_O === 1'b1 : INT_RESET_O === 1'b0)) begin
      @(posedge CLK_I);
      #1;
      k++;
    end
  endtask
  task automatic clr_req();
    @(posedge CLK_I);
    IRQ_REQ_CLR_I <= 1'b1;
    @(posedge CLK_I);
    IRQ_REQ_CLR_I <= 1'b0;
  endtask
  // Supply thresholds in mV, highest at code 0
  function automatic int thr_mv(input logic [3:0] c);
    int t [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                   3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
    return t[c];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    rdc(`LVD_ADDR_DIR, `LVD_DIR_RST);
    rdc(`LVD_ADDR_CTL, `LVD_CTL_RST);
    rdc(`LVD_ADDR_LVL, `LVD_LVL_RST);
    rdc(16'h1234, 8'h00);
    `CHK(IRQ_MASK_O, 1'b1)
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      wr(`LVD_ADDR_CTL, d & 8'h7F);
      rdc(`LVD_ADDR_CTL, d & 8'h06);
      wr(`LVD_ADDR_LVL, d & 8'h0F);
      rdc(`LVD_ADDR_LVL, d & 8'h0F);
      wr(`LVD_ADDR_DIR, d);
      #1;
      `CHK(PORT12_DIR_O, d | 8'hFE)
    end
    wr(`LVD_ADDR_CTL, 8'h00);
    wr(`LVD_ADDR_LVL, 8'h00);
    bw(`LVD_ADDR_CTL, 2, 1'b1);
    bw(`LVD_ADDR_CTL, 0, 1'b1);
    rdc(`LVD_ADDR_CTL, 8'h04);
    bw(`LVD_ADDR_LVL, 3, 1'b1);
    rdc(`LVD_ADDR_LVL, 8'h08);
    wr(`LVD_ADDR_DIR, 8'hFF);
    $display("test registers done");
    code = 4'($random(seed));
    wr(`LVD_ADDR_LVL, {4'h0, code});
    thr = thr_mv(code);
    // Equal to threshold counts as above
    setv(thr, 3000);
    `CHK(LEVEL_CODE_O, code)
    wr(`LVD_ADDR_CTL, 8'h80);
    #1;
    `CHK(COMP_EN_O, 1'b1)
    repeat (5) @(posedge CLK_I);
    rdc(`LVD_ADDR_CTL, 8'h80);
    setv(thr - 1, 3000);
    wait_ev(0, n);
    `CHK(n >= FLT && n <= FLT + 6, 1'b1)
    @(posedge CLK_I);
    #1;
    `CHK(IRQ_REQ_FLAG_O, 1'b1)
    rdc(`LVD_ADDR_CTL, 8'h81);
    clr_req();
    setv(thr, 3000);
    wait_ev(0, n);
    `CHK(n <= 6, 1'b1)
    rdc(`LVD_ADDR_CTL, 8'h80);
    setv(thr - 1, 3000);
    wait_ev(0, n);
    clr_req();
    #1;
    `CHK(IRQ_REQ_FLAG_O, 1'b0)
    wr(`LVD_ADDR_CTL, 8'h00);
    wait_ev(0, n);
    `CHK(n <= 3, 1'b1)
    @(posedge CLK_I);
    #1;
    `CHK(IRQ_REQ_FLAG_O, 1'b1)
    `CHK(DET_IRQ_O, 1'b0)
    rdc(`LVD_ADDR_CTL, 8'h00);
    $display("test supply_irq done");
    wr(`LVD_ADDR_LVL, 8'h0F);
    setv(5000, 1210);
    wr(`LVD_ADDR_CTL, 8'h84);
    repeat (5) @(posedge CLK_I);
    setv(5000, 1209);
    wait_ev(0, n);
    `CHK(n >= FLT && n <= FLT + 6, 1'b1)
    rdc(`LVD_ADDR_CTL, 8'h85);
    // Supply far below must not matter here
    setv(1000, 1210);
    wait_ev(0, n);
    `CHK(n <= 6, 1'b1)
    rdc(`LVD_ADDR_CTL, 8'h84);
    wr(`LVD_ADDR_CTL, 8'h00);
    $display("test ext_irq done");
    @(posedge CLK_I);
    MASK_WR_I <= 1'b1;
    MASK_VAL_I <= 1'b0;
    @(posedge CLK_I);
    MASK_WR_I <= 1'b0;
    bw(`LVD_ADDR_DIR, 0, 1'b0);
    rdc(`LVD_ADDR_DIR, 8'hFE);
    `CHK(IRQ_MASK_O, 1'b0)
    setv(5000, 3000);
    wr(`LVD_ADDR_CTL, 8'h82);
    setv(1900, 3000);
    wait_ev(1, n);
    `CHK(n >= FLT && n <= FLT + 6, 1'b1)
    repeat (2) @(posedge CLK_I);
    #1;
    `CHK(RST_SRC_FLAG_O, 1'b1)
    `CHK(IRQ_MASK_O, 1'b1)
    `CHK(PORT12_DIR_O, 8'hFF)
    // Held in detector reset, so dropped
    wr(`LVD_ADDR_CTL, 8'h00);
    setv(5000, 3000);
    wait_ev(2, n);
    `CHK(n <= 6, 1'b1)
    rdc(`LVD_ADDR_CTL, 8'h82);
    rdc(`LVD_ADDR_LVL, 8'h0F);
    rdc(`LVD_ADDR_DIR, 8'hFF);
    @(posedge CLK_I);
    RST_SRC_CLR_I <= 1'b1;
    MASK_WR_I <= 1'b1;
    @(posedge CLK_I);
    RST_SRC_CLR_I <= 1'b0;
    MASK_WR_I <= 1'b0;
    #1;
    `CHK(RST_SRC_FLAG_O, 1'b0)
    `CHK(IRQ_MASK_O, 1'b0)
    bw(`LVD_ADDR_DIR, 0, 1'b0);
    @(posedge CLK_I);
    RESETN_I <= 1'b0;
    repeat (6) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    rdc(`LVD_ADDR_CTL, 8'h00);
    rdc(`LVD_ADDR_LVL, 8'h00);
    rdc(`LVD_ADDR_DIR, `LVD_DIR_RST);
    `CHK(IRQ_MASK_O, 1'b1)
    $display("test reset_mode done");
    end_sim();
  end
endmodule // low_voltage_detect_control_tb
`default_nettype wire
